// >>> verilog/nvmac_top.sv
// Register front end and unlock guard for the data nonvolatile memory.
`timescale 1ns/1ps
// Overview of operation
// - 128 byte locations addressed by index bits 6..0, 0h to 7Fh.
// - A program erases the byte then writes it, no erase command.
// - Program duration is timed by an internal counter.
// - Fetch and program triggers are set-only; hardware clears them.
// - Fetch loads the data register the next cycle and self-clears.
// - Data register holds until next fetch or software write.
// - Program needs 55h, AAh to unlock port, then trigger.
// - Unlock sequence must take an exact cycle count.
// - Program trigger cannot be set while permit is clear.
// - Clearing permit mid-program is harmless; hardware clears it only on reset.
// - Permit is clear after power-up.
// - Program end clears trigger, sets done flag; software clears flag.
// - Warm reset during a program sets abort; data and index kept.
// - Unlock port has no storage and reads zero.
// - Programs are refused while the power-up timer runs.
// - Code protection blocks only the external programmer.
// - Control: abort bit3, permit bit2, program bit1, fetch bit0.
////////////////////////////////////////////////////////////////////////////////
module nvmac_top
   import nvmac_pkg::*;
#(
   parameter int PROG_CYCLES  = NVMAC_PROG_CYCLES,
   parameter int PWRUP_CYCLES = NVMAC_PWRUP_CYCLES
) (
   // Clock and resets.
   input  wire logic       CLK_I,
   input  wire logic       NRST_I,
   input  wire logic       POR_I,
   input  wire logic       WARM_RESET_I,
   // Register port of the CPU.
   input  wire logic [7:0] ADDR_I,
   input  wire logic [7:0] WDATA_I,
   input  wire logic       WR_I,
   input  wire logic       RD_I,
   output logic [7:0]      RDATA_O,
   // Flag and protection.
   input  wire logic       DONE_CLR_I,
   input  wire logic       CODE_PROTECT_I,
   input  wire logic       EXT_PROG_REQ_I,
   output logic            DONE_FLAG_O,
   output logic            EXT_ACCESS_OK_O
);
   logic [7:0]    index_reg;
   logic [7:0]    data_reg;
   logic          permit_reg;
   logic          abort_reg;
   logic          program_reg;
   logic          fetch_reg;
   logic          done_reg;
   logic [31:0]   pwrup_reg;
   logic [2:0]    gap_reg;
   nvmac_unlock_e unl_reg;
   nvmac_unlock_e unl_next;
   logic [7:0]    arr_rdata;
   logic          arr_busy;
   logic          arr_done;
   // One decode for every register hit keeps all write strobes in step.
   function automatic logic reg_hit(input logic [7:0] addr,
                                    input logic [7:0] ofs);
      return addr == ofs;
   endfunction
   wire wr_index   = WR_I && reg_hit(ADDR_I, NVMAC_OFS_INDEX);
   wire wr_data    = WR_I && reg_hit(ADDR_I, NVMAC_OFS_DATA);
   wire wr_control = WR_I && reg_hit(ADDR_I, NVMAC_OFS_CONTROL);
   wire wr_unlock  = WR_I && reg_hit(ADDR_I, NVMAC_OFS_UNLOCK);
   wire pwrup_run  = (pwrup_reg != 32'h0);
   wire set_prog   = wr_control && WDATA_I[NVMAC_BIT_PROGRAM];
   wire prog_ok    = set_prog && permit_reg && !pwrup_run
                     && !program_reg && (unl_reg == NVMAC_ST_KEY2)
                     && (gap_reg == NVMAC_GAP_TRIG);
   wire set_fetch  = wr_control && WDATA_I[NVMAC_BIT_FETCH];
   wire cut        = WARM_RESET_I && arr_busy;
   wire [7:0] ctl_rd = {4'h0, abort_reg, permit_reg, program_reg,
                        fetch_reg};
   ////////////////////////////////////////////////////////////////////////////
   nvmac_array #(
      .PROG_CYCLES (PROG_CYCLES)
   ) u_array (
      .clk_i   (CLK_I),
      .nrst_i  (POR_I ? 1'b0 : 1'b1),
      .addr_i  (index_reg[NVMAC_ADDR_W-1:0]),
      .wdata_i (data_reg),
      .start_i (prog_ok),
      .cut_i   (cut),
      .rdata_o (arr_rdata),
      .busy_o  (arr_busy),
      .done_o  (arr_done)
   );
   // The CPU path ignores code protection entirely.
   assign EXT_ACCESS_OK_O = !CODE_PROTECT_I && EXT_PROG_REQ_I;
   assign DONE_FLAG_O     = done_reg;
   // Read mux; the unlock port has no storage and returns zero.
   always_comb begin
      case (ADDR_I)
         NVMAC_OFS_INDEX:   RDATA_O = index_reg;
         NVMAC_OFS_DATA:    RDATA_O = data_reg;
         NVMAC_OFS_CONTROL: RDATA_O = ctl_rd;
         NVMAC_OFS_UNLOCK:  RDATA_O = 8'h00;
         default:           RDATA_O = 8'h00;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////
   // Unlock tracker; a stray write in between breaks the count.
   always_comb begin
      unl_next = unl_reg;
      case (unl_reg)
         NVMAC_ST_IDLE: begin
            if (wr_unlock && WDATA_I == NVMAC_KEY_FIRST) begin
               unl_next = NVMAC_ST_KEY1;
            end
         end
         NVMAC_ST_KEY1: begin
            if (wr_unlock && WDATA_I == NVMAC_KEY_SECOND
                && gap_reg == NVMAC_GAP_KEY) begin
               unl_next = NVMAC_ST_KEY2;
            end else if (WR_I || gap_reg > NVMAC_GAP_KEY) begin
               unl_next = NVMAC_ST_IDLE;
            end
         end
         NVMAC_ST_KEY2: begin
            if (WR_I || gap_reg >= NVMAC_GAP_TRIG) begin
               unl_next = NVMAC_ST_IDLE;
            end
         end
         default: unl_next = NVMAC_ST_IDLE;
      endcase
   end
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         unl_reg <= NVMAC_ST_IDLE;
         gap_reg <= 3'h0;
      end else begin
         unl_reg <= unl_next;
         // Loading one on a step makes the count equal the cycles since
         // the last key write, so the gap constants read as plain cycles.
         gap_reg <= (unl_next != unl_reg) ? 3'h1 : gap_reg + 3'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Power-up timer only runs after a cold start.
   always_ff @(posedge CLK_I) begin
      if (POR_I) begin
         pwrup_reg <= 32'(PWRUP_CYCLES);
      end else if (pwrup_run) begin
         pwrup_reg <= pwrup_reg - 32'h1;
      end
   end
   // Index and data survive warm resets so software can retry.
   always_ff @(posedge CLK_I) begin
      if (POR_I) begin
         index_reg <= 8'h00;
         data_reg  <= 8'h00;
      end else begin
         if (wr_index) begin
            index_reg <= WDATA_I;
         end
         if (fetch_reg) begin
            data_reg <= arr_rdata;
         end else if (wr_data) begin
            data_reg <= WDATA_I;
         end
      end
   end
   // Control bits. Warm reset clears triggers and permit but keeps abort.
   always_ff @(posedge CLK_I) begin
      if (POR_I) begin
         permit_reg  <= 1'b0;
         abort_reg   <= 1'b0;
         program_reg <= 1'b0;
         fetch_reg   <= 1'b0;
         done_reg    <= 1'b0;
      end else if (!NRST_I || WARM_RESET_I) begin
         permit_reg  <= 1'b0;
         program_reg <= 1'b0;
         fetch_reg   <= 1'b0;
         if (cut) begin
            abort_reg <= 1'b1;
         end
      end else begin
         // Software may only set the triggers, never clear them.
         fetch_reg <= set_fetch && !fetch_reg;
         if (prog_ok) begin
            program_reg <= 1'b1;
         end else if (arr_done) begin
            program_reg <= 1'b0;
         end
         if (wr_control) begin
            permit_reg <= WDATA_I[NVMAC_BIT_PERMIT];
            abort_reg  <= WDATA_I[NVMAC_BIT_ABORT];
         end
         // Completion wins over a same-cycle clear.
         if (arr_done) begin
            done_reg <= 1'b1;
         end else if (DONE_CLR_I) begin
            done_reg <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   a_fetch_next: assert property (
      @(posedge CLK_I) disable iff (!NRST_I || POR_I || WARM_RESET_I)
      fetch_reg |=> !fetch_reg && data_reg == $past(arr_rdata))
      else $error("fetch not completed next cycle");
   a_prog_permit: assert property (
      @(posedge CLK_I) disable iff (!NRST_I)
      $rose(program_reg) |-> $past(permit_reg))
      else $error("program set without permit");
   a_prog_unlock: assert property (
      @(posedge CLK_I) disable iff (!NRST_I)
      $rose(program_reg) |-> $past(unl_reg) == NVMAC_ST_KEY2)
      else $error("program set without unlock");
   a_prog_pwrup: assert property (
      @(posedge CLK_I) disable iff (!NRST_I)
      $rose(program_reg) |-> !$past(pwrup_run))
      else $error("program during power-up");
   a_done_sets: assert property (
      @(posedge CLK_I) disable iff (!NRST_I || POR_I || WARM_RESET_I)
      arr_done |=> done_reg && !program_reg)
      else $error("completion not flagged");
   a_unlock_zero: assert property (
      @(posedge CLK_I) disable iff (!NRST_I)
      ADDR_I == NVMAC_OFS_UNLOCK |-> RDATA_O == 8'h00)
      else $error("unlock port read nonzero");
   a_ctl_upper: assert property (
      @(posedge CLK_I) disable iff (!NRST_I)
      ADDR_I == NVMAC_OFS_CONTROL |-> RDATA_O[7:4] == 4'h0)
      else $error("control upper bits nonzero");
   a_abort_cut: assert property (
      @(posedge CLK_I) disable iff (POR_I)
      cut |=> abort_reg && $stable(index_reg))
      else $error("abort not flagged");
   a_trig_hold: assert property (
      @(posedge CLK_I) disable iff (!NRST_I || POR_I || WARM_RESET_I)
      program_reg && !arr_done |=> program_reg)
      else $error("program trigger dropped early");
   ////////////////////////////////////////////////////////////////////////////
   // Steps of the unlock sequence as the tracker is meant to see them.
   sequence s_key_first;
      wr_unlock && WDATA_I == NVMAC_KEY_FIRST && unl_reg == NVMAC_ST_IDLE;
   endsequence
   sequence s_key_second;
      wr_unlock && WDATA_I == NVMAC_KEY_SECOND;
   endsequence
   sequence s_unlock_keys;
      s_key_first ##1 !WR_I ##1 s_key_second;
   endsequence
   sequence s_trig_ready;
      set_prog && permit_reg && !pwrup_run && !program_reg;
   endsequence
   a_unlock_reach: assert property (
      @(posedge CLK_I) disable iff (!NRST_I)
      s_unlock_keys |=> unl_reg == NVMAC_ST_KEY2)
      else $error("unlock keys not accepted");
   a_trig_start: assert property (
      @(posedge CLK_I) disable iff (!NRST_I || POR_I || WARM_RESET_I)
      s_unlock_keys ##1 s_trig_ready |=> program_reg)
      else $error("unlocked trigger did not start a program");
   a_gap_short: assert property (
      @(posedge CLK_I) disable iff (!NRST_I)
      s_key_first ##1 s_key_second |=> unl_reg == NVMAC_ST_IDLE)
      else $error("second key accepted too early");
   a_gap_long: assert property (
      @(posedge CLK_I) disable iff (!NRST_I)
      s_key_first ##1 !WR_I [*2] ##1 s_key_second
      |=> unl_reg == NVMAC_ST_IDLE)
      else $error("second key accepted too late");
   a_stray_idle: assert property (
      @(posedge CLK_I) disable iff (!NRST_I)
      unl_reg == NVMAC_ST_KEY1 && WR_I && !wr_unlock
      |=> unl_reg == NVMAC_ST_IDLE)
      else $error("stray write kept the unlock armed");
   a_permit_kept: assert property (
      @(posedge CLK_I) disable iff (!NRST_I || POR_I || WARM_RESET_I)
      program_reg && !arr_done && wr_control
      && !WDATA_I[NVMAC_BIT_PERMIT] |=> program_reg)
      else $error("clearing permit stopped the program");
   a_permit_hold: assert property (
      @(posedge CLK_I) disable iff (!NRST_I || POR_I || WARM_RESET_I)
      permit_reg && !wr_control |=> permit_reg)
      else $error("permit cleared by hardware");
   a_pwrup_clear: assert property (
      @(posedge CLK_I)
      POR_I |=> !permit_reg)
      else $error("permit set after power-up");
   a_data_cut: assert property (
      @(posedge CLK_I) disable iff (POR_I)
      cut && !fetch_reg |=> $stable(data_reg))
      else $error("data register changed by abort");
   // Age of the running program, so its length is checked without a long
   // repetition that the tools would have to unroll.
   logic [31:0] prog_age_reg;
   always_ff @(posedge CLK_I) begin
      if (!program_reg) begin
         prog_age_reg <= 32'h0;
      end else begin
         prog_age_reg <= prog_age_reg + 32'h1;
      end
   end
   a_prog_length: assert property (
      @(posedge CLK_I) disable iff (!NRST_I || POR_I || WARM_RESET_I)
      arr_done |-> prog_age_reg == 32'(PROG_CYCLES) - 32'h1)
      else $error("program length differs from its setting");
endmodule

// >>> verilog/nvmac_pkg.sv
// Package with register offsets, bit positions and timing for the controller.
package nvmac_pkg;
   localparam logic [7:0] NVMAC_OFS_DATA    = 8'h9a;
   localparam logic [7:0] NVMAC_OFS_INDEX   = 8'h9b;
   localparam logic [7:0] NVMAC_OFS_CONTROL = 8'h9c;
   localparam logic [7:0] NVMAC_OFS_UNLOCK  = 8'h9d;
   localparam int NVMAC_BIT_ABORT   = 3;
   localparam int NVMAC_BIT_PERMIT  = 2;
   localparam int NVMAC_BIT_PROGRAM = 1;
   localparam int NVMAC_BIT_FETCH   = 0;
   localparam logic [7:0] NVMAC_KEY_FIRST  = 8'h55;
   localparam logic [7:0] NVMAC_KEY_SECOND = 8'haa;
   localparam int NVMAC_DEPTH       = 128;
   localparam int NVMAC_ADDR_W      = 7;
   // Cycles from the first key write to the second, and from the second to the trigger.
   localparam logic [2:0] NVMAC_GAP_KEY  = 3'h2;
   localparam logic [2:0] NVMAC_GAP_TRIG = 3'h1;
   localparam int NVMAC_CLK_MHZ      = 100;
   localparam int NVMAC_PROG_US      = 4000;
   localparam int NVMAC_PROG_CYCLES  = NVMAC_PROG_US * NVMAC_CLK_MHZ;
   localparam int NVMAC_PWRUP_MS     = 72;
   localparam int NVMAC_PWRUP_CYCLES = NVMAC_PWRUP_MS * 1000 * NVMAC_CLK_MHZ;
   typedef enum logic [1:0] {
      NVMAC_ST_IDLE  = 2'b00,
      NVMAC_ST_KEY1  = 2'b01,
      NVMAC_ST_KEY2  = 2'b11
   } nvmac_unlock_e;
endpackage

// >>> verilog/nvmac_array.sv
// Storage array of the data nonvolatile memory with a self-timed program.
`timescale 1ns/1ps
module nvmac_array
   import nvmac_pkg::*;
#(
   parameter int PROG_CYCLES = NVMAC_PROG_CYCLES
) (
   input  wire logic                    clk_i,
   input  wire logic                    nrst_i,
   // Access.
   input  wire logic [NVMAC_ADDR_W-1:0] addr_i,
   input  wire logic [7:0]              wdata_i,
   input  wire logic                    start_i,
   input  wire logic                    cut_i,
   output logic [7:0]                   rdata_o,
   output logic                         busy_o,
   output logic                         done_o
);
   logic [7:0]              mem_reg [NVMAC_DEPTH];
   logic [31:0]             cnt_reg;
   logic [NVMAC_ADDR_W-1:0] addr_reg;
   logic [7:0]              data_reg;
   logic                    busy_reg;
   logic                    last;
   assign last    = busy_reg && (cnt_reg == 32'h1);
   assign rdata_o = mem_reg[addr_i];
   assign busy_o  = busy_reg;
   assign done_o  = last && !cut_i;
   // Cells keep their contents through reset, as a real array would.
   always_ff @(posedge clk_i) begin
      if (!nrst_i || cut_i) begin
         busy_reg <= 1'b0;
         cnt_reg  <= 32'h0;
      end else if (start_i && !busy_reg) begin
         busy_reg <= 1'b1;
         cnt_reg  <= 32'(PROG_CYCLES);
         addr_reg <= addr_i;
         data_reg <= wdata_i;
      end else if (busy_reg) begin
         cnt_reg <= cnt_reg - 32'h1;
         if (last) begin
            busy_reg <= 1'b0;
         end
      end
   end
   // Erase is implied: the whole byte is replaced, no erase command.
   always_ff @(posedge clk_i) begin
      if (nrst_i && !cut_i && last) begin
         mem_reg[addr_reg] <= data_reg;
      end
   end
endmodule

// >>> tb/nvmac_top_bench.sv
// Self-checking bench for the nonvolatile data memory controller.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
   $display("FAIL %0t got %h exp %h", $time, g, e); end end
////////////////////////////////////////////////////////////////////////////////
module nvmac_top_bench;
   import nvmac_pkg::*;
   // Short counts keep the run brief; the power-up span outlasts the first program attempt.
   localparam int PROG = 8;
   localparam int PWUP = 20;
   logic       clk_i = 1'b0;
   logic       nrst_i = 1'b0;
   logic       por_i = 1'b1;
   logic       warm_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic       wr_i = 1'b0;
   logic       rd_i = 1'b0;
   logic       clr_i = 1'b0;
   logic       prot_i = 1'b0;
   logic       ext_i = 1'b0;
   logic [7:0] rdata_o;
   logic       done_o;
   logic       ext_ok_o;
   int         failures = 0;
   int         checks = 0;
   int         k;
   logic [7:0] bad [5][4] = '{'{8'h55, 8'haa, 8'h02, 8'h02},
      '{8'h55, 8'haa, 8'h01, 8'h06}, '{8'h55, 8'haa, 8'h03, 8'h06},
      '{8'haa, 8'h55, 8'h02, 8'h06}, '{8'h55, 8'haa, 8'h12, 8'h06}};
   always #5 clk_i = ~clk_i;
   nvmac_top #(.PROG_CYCLES(PROG), .PWRUP_CYCLES(PWUP)) dut (
      .CLK_I(clk_i), .NRST_I(nrst_i), .POR_I(por_i), .WARM_RESET_I(warm_i),
      .ADDR_I(addr_i), .WDATA_I(wdata_i), .WR_I(wr_i), .RD_I(rd_i),
      .RDATA_O(rdata_o), .DONE_CLR_I(clr_i), .CODE_PROTECT_I(prot_i),
      .EXT_PROG_REQ_I(ext_i), .DONE_FLAG_O(done_o),
      .EXT_ACCESS_OK_O(ext_ok_o));
   ////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr_i = a; wdata_i = d; wr_i = 1'b1; rd_i = 1'b0;
      @(posedge clk_i); #1;
   endtask
   task automatic idle(input int n);
      wr_i = 1'b0;
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Reads are combinational, so the value is compared within the cycle.
   task automatic rd(input logic [7:0] a, m, e);
      addr_i = a; wr_i = 1'b0; rd_i = 1'b1;
      #1;
      `CHK(rdata_o & m, e)
      @(posedge clk_i); #1;
   endtask
   // A gap code above 8'h0f replaces the idle slot with a stray write.
   task automatic unl(input logic [7:0] k1, k2, gap, trig);
      wr(NVMAC_OFS_UNLOCK, k1);
      if (gap > 8'h0f) wr(NVMAC_OFS_INDEX, 8'h05);
      else if (gap > 8'h01) idle(gap - 1);
      wr(NVMAC_OFS_UNLOCK, k2);
      wr(NVMAC_OFS_CONTROL, trig);
   endtask
   task automatic prog(input logic [7:0] a, d);
      wr(NVMAC_OFS_INDEX, a);
      wr(NVMAC_OFS_DATA, d);
      wr(NVMAC_OFS_CONTROL, 8'h04);
      unl(8'h55, 8'haa, 8'h02, 8'h06);
   endtask
   task automatic fetch(input logic [7:0] a, e);
      wr(NVMAC_OFS_INDEX, a);
      wr(NVMAC_OFS_CONTROL, 8'h01);
      idle(1);
      rd(NVMAC_OFS_CONTROL, 8'h01, 8'h00);
      rd(NVMAC_OFS_DATA, 8'hff, e);
   endtask
   task automatic finish_prog;
      // The last write of a program leaves the strobe up; drop it so the
      // wait does not keep rewriting the control register.
      wr_i = 1'b0;
      k = 0;
      while (done_o !== 1'b1 && k < PROG + 4) begin
         @(posedge clk_i); #1; k++;
      end
      rd(NVMAC_OFS_CONTROL, 8'h02, 8'h00);
      idle(2);
      `CHK(done_o, 1'b1)
      clr_i = 1'b1;
      idle(1);
      clr_i = 1'b0;
      idle(1);
      `CHK(done_o, 1'b0)
   endtask
   task automatic end_sim;
      $display("Counts: %0d checks, %0d failures", checks, failures);
      if (failures == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #50000;
      failures++;
      end_sim();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      #1;
      nrst_i = 1'b1; por_i = 1'b0;
      rd(NVMAC_OFS_CONTROL, 8'h04, 8'h00);
      prog(8'h05, 8'h3c);
      rd(NVMAC_OFS_CONTROL, 8'h02, 8'h00);
      idle(PWUP);
      rd(NVMAC_OFS_CONTROL, 8'hf0, 8'h00);
      rd(NVMAC_OFS_UNLOCK, 8'hff, 8'h00);
      rd(8'h9e, 8'hff, 8'h00);
      $display("Test reset and power-up done");
      prot_i = 1'b1;
      prog(8'h05, 8'h3c);
      rd(NVMAC_OFS_CONTROL, 8'h06, 8'h06);
      `CHK(done_o, 1'b0)
      wr(NVMAC_OFS_CONTROL, 8'h00);
      rd(NVMAC_OFS_CONTROL, 8'h06, 8'h02);
      finish_prog();
      prog(8'h7f, 8'hc3);
      finish_prog();
      prog(8'h05, 8'h5a);
      finish_prog();
      fetch(8'h7f, 8'hc3);
      fetch(8'h05, 8'h5a);
      wr(NVMAC_OFS_DATA, 8'h99);
      idle(3);
      rd(NVMAC_OFS_DATA, 8'hff, 8'h99);
      $display("Test program and fetch done");
      for (int i = 0; i < 5; i++) begin
         wr(NVMAC_OFS_INDEX, 8'h05);
         wr(NVMAC_OFS_DATA, 8'h11);
         // A trigger code without the permit bit leaves permit clear here.
         wr(NVMAC_OFS_CONTROL, bad[i][3] & 8'h04);
         unl(bad[i][0], bad[i][1], bad[i][2], bad[i][3]);
         rd(NVMAC_OFS_CONTROL, 8'h02, 8'h00);
      end
      idle(PROG + 3);
      `CHK(done_o, 1'b0)
      fetch(8'h05, 8'h5a);
      $display("Test refused sequences done");
      prog(8'h33, 8'he7);
      idle(2);
      warm_i = 1'b1;
      idle(1);
      warm_i = 1'b0;
      rd(NVMAC_OFS_CONTROL, 8'h0a, 8'h08);
      rd(NVMAC_OFS_INDEX, 8'hff, 8'h33);
      rd(NVMAC_OFS_DATA, 8'hff, 8'he7);
      idle(PROG + 3);
      `CHK(done_o, 1'b0)
      $display("Test abort done");
      ext_i = 1'b1;
      #1;
      `CHK(ext_ok_o, 1'b0)
      prot_i = 1'b0;
      #1;
      `CHK(ext_ok_o, 1'b1)
      $display("Test code protection done");
      end_sim();
   end
endmodule
